// ==== rtl/dgr_consts.svh ====
`ifndef DGR_CONSTS_SVH
`define DGR_CONSTS_SVH

// Register offsets on the internal register port.
`define DGR_OFF_STATE 8'h14
`define DGR_OFF_IN_DUTY 8'h16
`define DGR_OFF_OUT_DUTY 8'h18
`define DGR_OFF_SINK 8'h1A
`define DGR_OFF_BOOST 8'h1C
`define DGR_OFF_CONFIG 8'h1E

// Field widths.
`define DGR_STATE_W 5
`define DGR_DUTY_W 16
`define DGR_SINK_W 12
`define DGR_BOOST_W 11
`define DGR_CODE3_W 3

// Field positions in the detected-configuration word.
`define DGR_DIMF_LSB 12
`define DGR_LAYOUT_LSB 8
`define DGR_SWF_LSB 3
`define DGR_MODE_LSB 0

// Reset values.
`define DGR_RST_WORD 16'h0000
`define DGR_RST_STATE 5'h00
`define DGR_RST_SINK 12'h000
`define DGR_RST_BOOST 11'h000

// Live state codes.
`define DGR_ST_OFF 5'h00
`define DGR_ST_REG_POWERUP 5'h01
`define DGR_ST_FUSE_LOAD 5'h02
`define DGR_ST_STANDBY 5'h03
`define DGR_ST_RAMP_FIRST 5'h04
`define DGR_ST_RAMP_LAST 5'h0F
`define DGR_ST_NORMAL 5'h10
`define DGR_ST_SHUTDOWN 5'h11
`define DGR_ST_FAULT_RETRY 5'h12
`define DGR_ST_ALL_FAILED 5'h13

`endif

// ==== rtl/dgr_pkg.sv ====
package dgr_pkg;

  typedef enum logic [2:0] {
    DGR_SEL_STATE,
    DGR_SEL_IN_DUTY,
    DGR_SEL_OUT_DUTY,
    DGR_SEL_SINK,
    DGR_SEL_BOOST,
    DGR_SEL_CONFIG,
    DGR_SEL_NONE
  } dgr_sel_t;

  typedef logic [15:0] dgr_word_t;

endpackage

// ==== rtl/dgr_detect_latch.sv ====
`timescale 1ns/10ps
`include "dgr_consts.svh"

module dgr_detect_latch (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Detection results.
  input wire logic detect_valid,
  input wire logic [2:0] detected_dim_freq,
  input wire logic [2:0] detected_string_layout,
  input wire logic [2:0] detected_switch_freq,
  input wire logic [2:0] detected_mode_addr,
  // Packed word.
  output dgr_pkg::dgr_word_t config_word
);

  dgr_pkg::dgr_word_t config_reg;

  // The resistors are sensed once after power-up, so the word is held between detections.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= `DGR_RST_WORD;
    end else if (detect_valid) begin
      config_reg <= '0;
      config_reg[`DGR_DIMF_LSB +: `DGR_CODE3_W] <= detected_dim_freq;
      config_reg[`DGR_LAYOUT_LSB +: `DGR_CODE3_W] <= detected_string_layout;
      config_reg[`DGR_SWF_LSB +: `DGR_CODE3_W] <= detected_switch_freq;
      config_reg[`DGR_MODE_LSB +: `DGR_CODE3_W] <= detected_mode_addr;
    end
  end

  assign config_word = config_reg;

  a_cfg_capture: assert property (@(posedge clk) disable iff (!rst_n)
    detect_valid |=> config_word == {1'b0, $past(detected_dim_freq), 1'b0, $past(detected_string_layout),
                                     2'b00, $past(detected_switch_freq), $past(detected_mode_addr)})
    else $error("Detected configuration not packed correctly.");

  a_cfg_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !detect_valid |=> $stable(config_word))
    else $error("Detected configuration changed without a detection.");

endmodule

// ==== rtl/dgr_diag_regs.sv ====
`timescale 1ns/10ps
`include "dgr_consts.svh"

module dgr_diag_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port from the serial control engine.
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_hit,
  // Live values from the device logic.
  input wire logic [4:0] live_state_code,
  input wire logic in_duty_valid,
  input wire logic [15:0] in_duty_code,
  input wire logic [15:0] out_duty_code,
  input wire logic [11:0] sink_current_code,
  input wire logic [10:0] boost_voltage_code,
  // Resistor detection results.
  input wire logic detect_valid,
  input wire logic [2:0] detected_dim_freq,
  input wire logic [2:0] detected_string_layout,
  input wire logic [2:0] detected_switch_freq,
  input wire logic [2:0] detected_mode_addr
);

  function automatic dgr_pkg::dgr_sel_t dgr_decode(input logic [7:0] addr);
    case (addr)
      `DGR_OFF_STATE: dgr_decode = dgr_pkg::DGR_SEL_STATE;
      `DGR_OFF_IN_DUTY: dgr_decode = dgr_pkg::DGR_SEL_IN_DUTY;
      `DGR_OFF_OUT_DUTY: dgr_decode = dgr_pkg::DGR_SEL_OUT_DUTY;
      `DGR_OFF_SINK: dgr_decode = dgr_pkg::DGR_SEL_SINK;
      `DGR_OFF_BOOST: dgr_decode = dgr_pkg::DGR_SEL_BOOST;
      `DGR_OFF_CONFIG: dgr_decode = dgr_pkg::DGR_SEL_CONFIG;
      default: dgr_decode = dgr_pkg::DGR_SEL_NONE;
    endcase
  endfunction

  // Reserved bits are padded in one place so the state, sink and boost words keep their upper bits at zero.
  function automatic dgr_pkg::dgr_word_t dgr_state_word(input logic [4:0] code);
    dgr_state_word = {11'h000, code};
  endfunction

  function automatic dgr_pkg::dgr_word_t dgr_sink_word(input logic [11:0] code);
    dgr_sink_word = {4'h0, code};
  endfunction

  function automatic dgr_pkg::dgr_word_t dgr_boost_word(input logic [10:0] code);
    dgr_boost_word = {5'h00, code};
  endfunction

  logic [4:0] state_reg;
  logic [15:0] in_duty_reg;
  logic [15:0] out_duty_reg;
  logic [11:0] sink_reg;
  logic [10:0] boost_reg;
  dgr_pkg::dgr_word_t config_word;
  dgr_pkg::dgr_sel_t rd_sel;
  dgr_pkg::dgr_word_t rdata_next;
  logic [15:0] rdata_reg;
  logic ack_reg;
  logic hit_reg;

  dgr_detect_latch u_detect (
    .clk(clk),
    .rst_n(rst_n),
    .detect_valid(detect_valid),
    .detected_dim_freq(detected_dim_freq),
    .detected_string_layout(detected_string_layout),
    .detected_switch_freq(detected_switch_freq),
    .detected_mode_addr(detected_mode_addr),
    .config_word(config_word)
  );

  // The live state code is sampled every cycle; the register port alone can never alter it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `DGR_RST_STATE;
    end else begin
      state_reg <= live_state_code;
    end
  end

  // The measured duty only moves when the measurement logic finishes a period.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_duty_reg <= `DGR_RST_WORD;
    end else if (in_duty_valid) begin
      in_duty_reg <= in_duty_code;
    end
  end

  // Output duty, sink and boost codes are levels, so they are simply resampled every cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_duty_reg <= `DGR_RST_WORD;
    end else begin
      out_duty_reg <= out_duty_code;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sink_reg <= `DGR_RST_SINK;
    end else begin
      sink_reg <= sink_current_code;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boost_reg <= `DGR_RST_BOOST;
    end else begin
      boost_reg <= boost_voltage_code;
    end
  end

  assign rd_sel = dgr_decode(reg_addr);

  always_comb begin
    rdata_next = `DGR_RST_WORD;
    case (rd_sel)
      dgr_pkg::DGR_SEL_STATE: rdata_next = dgr_state_word(state_reg);
      dgr_pkg::DGR_SEL_IN_DUTY: rdata_next = in_duty_reg;
      dgr_pkg::DGR_SEL_OUT_DUTY: rdata_next = out_duty_reg;
      dgr_pkg::DGR_SEL_SINK: rdata_next = dgr_sink_word(sink_reg);
      dgr_pkg::DGR_SEL_BOOST: rdata_next = dgr_boost_word(boost_reg);
      dgr_pkg::DGR_SEL_CONFIG: rdata_next = config_word;
      default: rdata_next = `DGR_RST_WORD;
    endcase
  end

  // Writes are acknowledged so the serial engine does not stall, but their data is dropped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= reg_rd | reg_wr;
    end
  end

  // A write to a mapped word still reports a hit, so the engine can tell a bad address from a refused write.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= (reg_rd | reg_wr) && (rd_sel != dgr_pkg::DGR_SEL_NONE);
    end
  end

  // Read data is captured in one cycle so a multi-bit value is never torn across bytes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `DGR_RST_WORD;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= `DGR_RST_WORD;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_ack = ack_reg;
  assign reg_hit = hit_reg;

  a_state_read: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_STATE |=> reg_ack && reg_rdata == {11'h000, $past(live_state_code, 2)})
    else $error("State word does not show the live state code.");

  a_state_resv: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_STATE |=> reg_rdata[15:5] == 11'h000)
    else $error("Reserved state bits are not zero.");

  a_in_duty_read: assert property (@(posedge clk) disable iff (!rst_n)
    in_duty_valid ##1 !in_duty_valid [*3] ##1 (!in_duty_valid && reg_rd && reg_addr == `DGR_OFF_IN_DUTY)
      |=> reg_rdata == $past(in_duty_code, 5))
    else $error("Input duty word does not show the last measurement.");

  a_in_duty_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !in_duty_valid |=> $stable(in_duty_reg))
    else $error("Input duty changed without a measurement.");

  a_out_duty_read: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_OUT_DUTY |=> reg_rdata == $past(out_duty_code, 2))
    else $error("Output duty word is wrong.");

  a_sink_read: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_SINK |=> reg_rdata == {4'h0, $past(sink_current_code, 2)})
    else $error("Sink current word is wrong.");

  a_boost_read: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_BOOST |=> reg_rdata == {5'h00, $past(boost_voltage_code, 2)})
    else $error("Boost voltage word is wrong.");

  a_cfg_resv: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_CONFIG |=> reg_rdata[15] == 1'b0 && reg_rdata == $past(config_word))
    else $error("Configuration word read is wrong.");

  a_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && !reg_rd && !detect_valid |=> reg_ack && reg_rdata == 16'h0000 && $stable(config_word))
    else $error("Write had an effect on the diagnostic words.");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && dgr_decode(reg_addr) == dgr_pkg::DGR_SEL_NONE |=> reg_ack && !reg_hit && reg_rdata == 16'h0000)
    else $error("Unmapped read did not return zero.");

  a_ack_single: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd && !reg_wr |=> !reg_ack)
    else $error("Acknowledge without a request.");

  // The checks below also pin down the port timing that the serial engine relies on.
  a_ack_follows: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd || reg_wr
      |=> reg_ack)
    else $error("Request was not acknowledged in the next cycle.");

  a_hit_needs_ack: assert property (@(posedge clk) disable iff (!rst_n)
    reg_hit
      |-> reg_ack)
    else $error("Hit flagged without an acknowledge.");

  a_hit_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd && !reg_wr
      |=> !reg_hit)
    else $error("Hit flagged without a request.");

  a_hit_mapped: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd || reg_wr) && dgr_decode(reg_addr) != dgr_pkg::DGR_SEL_NONE
      |=> reg_hit)
    else $error("Mapped access did not report a hit.");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd
      |=> reg_rdata == 16'h0000)
    else $error("Read data not zero outside a read.");

  a_sink_resv: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_SINK
      |=> reg_rdata[15:12] == 4'h0)
    else $error("Reserved sink current bits are not zero.");

  a_boost_resv: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_BOOST
      |=> reg_rdata[15:11] == 5'h00)
    else $error("Reserved boost voltage bits are not zero.");

  a_cfg_gap_zero: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_CONFIG
      |=> reg_rdata[11] == 1'b0 && reg_rdata[7:6] == 2'b00)
    else $error("Unused configuration bits are not zero.");

  a_state_tracks: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1
      |=> state_reg == $past(live_state_code))
    else $error("State copy does not follow the live state code.");

  a_out_tracks: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1
      |=> out_duty_reg == $past(out_duty_code))
    else $error("Output duty copy does not follow its source.");

  a_sink_tracks: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1
      |=> sink_reg == $past(sink_current_code))
    else $error("Sink current copy does not follow its source.");

  a_boost_tracks: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1
      |=> boost_reg == $past(boost_voltage_code))
    else $error("Boost voltage copy does not follow its source.");

  a_in_duty_load: assert property (@(posedge clk) disable iff (!rst_n)
    in_duty_valid
      |=> in_duty_reg == $past(in_duty_code))
    else $error("Input duty not loaded on a measurement.");

  a_in_duty_word: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_IN_DUTY
      |=> reg_rdata == $past(in_duty_reg))
    else $error("Input duty read does not show the held word.");

  a_read_no_effect: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && !detect_valid
      |=> $stable(config_word))
    else $error("Read changed the detected configuration.");

  c_read_normal: cover property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_STATE && state_reg == `DGR_ST_NORMAL);

  c_read_ramp: cover property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `DGR_OFF_STATE && state_reg >= `DGR_ST_RAMP_FIRST && state_reg <= `DGR_ST_RAMP_LAST);

  c_read_config: cover property (@(posedge clk) disable iff (!rst_n)
    detect_valid ##[1:20] (reg_rd && reg_addr == `DGR_OFF_CONFIG));

  c_write_dropped: cover property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `DGR_OFF_OUT_DUTY && reg_wdata != 16'h0000);

  c_read_unmapped: cover property (@(posedge clk) disable iff (!rst_n)
    reg_rd && dgr_decode(reg_addr) == dgr_pkg::DGR_SEL_NONE);

endmodule

// ==== bench/dgr_host.sv ====
`timescale 1ns/10ps

module dgr_host (
  // Clock.
  input wire logic clk,
  // Register port toward the block.
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_hit
);
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end

  // One pulse per access, answer taken after the following edge has landed.
  // Released address and write-data lines show the inverse of their last value, so a stale address cannot pass for a held one.
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ack, output logic hit);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_wr = wr;
    reg_rd = !wr;
    reg_wdata = wd;
    @(posedge clk);
    #2;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~wd;
    rd = reg_rdata;
    ack = reg_ack;
    hit = reg_hit;
  endtask
endmodule

// ==== bench/led_driver_diag_regs_tb.sv ====
`timescale 1ns/10ps
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp); end end

module led_driver_diag_regs_tb;
  logic clk = 1'b0, rst_n = 1'b0, in_v = 1'b0, det_v = 1'b0, ack, hit, got_ack, got_hit;
  logic [7:0] addr;
  logic rd, wr;
  logic [15:0] wdata, rdata, ind = 16'h0000, in_code = 16'h0000, outd = 16'h0000, d;
  logic [4:0] st = 5'h00;
  logic [11:0] snk = 12'h000;
  logic [10:0] bst = 11'h000;
  logic [2:0] df = 3'h0, lay = 3'h0, sw = 3'h0, md = 3'h0, f0 = 3'h0, f1 = 3'h0, f2 = 3'h0, f3 = 3'h0;
  int num_errors = 0, checks_done = 0;

  always #25 clk = ~clk;

  dgr_diag_regs dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack), .reg_hit(hit), .live_state_code(st),
    .in_duty_valid(in_v), .in_duty_code(in_code), .out_duty_code(outd), .sink_current_code(snk),
    .boost_voltage_code(bst), .detect_valid(det_v), .detected_dim_freq(f0),
    .detected_string_layout(f1), .detected_switch_freq(f2), .detected_mode_addr(f3));

  dgr_host host (.clk(clk), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_ack(ack), .reg_hit(hit));

  function automatic logic [15:0] exp_word(input logic [7:0] a);
    case (a)
      8'h14: exp_word = {11'h000, st};
      8'h16: exp_word = ind;
      8'h18: exp_word = outd;
      8'h1a: exp_word = {4'h0, snk};
      8'h1c: exp_word = {5'h00, bst};
      8'h1e: exp_word = {1'b0, df, 1'b0, lay, 2'b00, sw, md};
      default: exp_word = 16'h0000;
    endcase
  endfunction

  task automatic rd_chk(input logic [7:0] a);
    host.access(1'b0, a, 16'h0000, d, got_ack, got_hit);
    `CHK(got_ack, 1'b1)
    `CHK(got_hit, (a[0] == 1'b0 && a >= 8'h14 && a <= 8'h1e))
    `CHK(d, exp_word(a))
  endtask

  task automatic check_all();
    rd_chk(8'h14);
    rd_chk(8'h16);
    rd_chk(8'h18);
    rd_chk(8'h1a);
    rd_chk(8'h1c);
    rd_chk(8'h1e);
  endtask

  // Captured words are loaded by a one-cycle pulse, then their sources move away.
  task automatic set_live(input int i);
    @(posedge clk);
    #2;
    st = 5'(i % 20);
    ind = 16'($urandom);
    in_code = ind;
    outd = 16'($urandom);
    snk = 12'($urandom);
    bst = 11'($urandom);
    df = 3'($urandom);
    lay = 3'($urandom_range(0, 4));
    sw = 3'($urandom);
    md = 3'($urandom);
    {f0, f1, f2, f3} = {df, lay, sw, md};
    in_v = 1'b1;
    det_v = 1'b1;
    @(posedge clk);
    #2;
    in_v = 1'b0;
    det_v = 1'b0;
    in_code = ~ind;
    {f0, f1, f2, f3} = ~{df, lay, sw, md};
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    num_errors++;
    conclude();
  end

  initial begin
    logic [15:0] junk;
    void'($urandom(32'h9b82));
    repeat (6) @(posedge clk);
    #2;
    rst_n = 1'b1;
    check_all();
    for (int i = 0; i < 24; i++) begin
      set_live(i);
      check_all();
      host.access(1'b1, 8'h14 + 8'(2 * (i % 6)), 16'hffff, junk, got_ack, got_hit);
      `CHK(got_ack, 1'b1)
      `CHK(got_hit, 1'b1)
      `CHK(junk, 16'h0000)
      check_all();
    end
    rd_chk(8'h15);
    rd_chk(8'h20);
    rd_chk(8'h00);
    @(posedge clk);
    #2;
    rst_n = 1'b0;
    ind = 16'h0000;
    {df, lay, sw, md} = 12'h000;
    @(posedge clk);
    #2;
    rst_n = 1'b1;
    check_all();
    conclude();
  end
endmodule
